// ==== afsl_pkg.sv ====
// Package for the automatic fan speed loop: register map, reset values,
// field positions, timing constants and carrier structs.
// Assumes a single 125 MHz system clock and a synchronous active-high reset.
package afsl_pkg;

  // Register offsets
  localparam logic [7:0] MAIN_CONFIGURATION_OFFSET  = 8'h00;
  localparam logic [7:0] FAN_CHARACTERISTICS_OFFSET = 8'h20;
  localparam logic [7:0] MIN_SPEED_OFFSET           = 8'h22;
  localparam logic [7:0] LOCAL_PARAM_OFFSET         = 8'h24;
  localparam logic [7:0] REMOTE_PARAM_OFFSET        = 8'h25;
  localparam logic [7:0] LOOP_STATUS_OFFSET         = 8'h26;

  // Reset values
  localparam logic [7:0] MAIN_CONFIGURATION_RESET  = 8'h80;
  localparam logic [7:0] FAN_CHARACTERISTICS_RESET = 8'h1D;
  localparam logic [7:0] MIN_SPEED_RESET           = 8'h05;
  localparam logic [7:0] LOCAL_PARAM_RESET         = 8'h40;
  localparam logic [7:0] REMOTE_PARAM_RESET        = 8'h60;

  // Field positions
  localparam int AUTO_MODE_BIT   = 7;
  localparam int CHAN_SEL_HI     = 6;
  localparam int CHAN_SEL_LO     = 5;
  localparam int SPIN_CODE_HI    = 2;
  localparam int FAN_ON_TEMP_HI  = 7;
  localparam int FAN_ON_TEMP_LO  = 3;
  localparam int SPAN_CODE_HI    = 2;
  localparam int MIN_CODE_HI     = 3;
  localparam int STATUS_SPIN_BIT = 4;
  localparam int STATUS_ON_BIT   = 5;

  localparam logic [1:0] CHAN_SEL_FASTEST = 2'h3;
  localparam logic [2:0] SPAN_CODE_MAX    = 3'h4;
  localparam logic [3:0] DUTY_FULL        = 4'hF;
  localparam logic [3:0] DUTY_OFF         = 4'h0;

  // Hysteresis below the fan-on temperature, degrees C
  localparam int HYSTERESIS_DEG = 5;

  // Spin-up timing: table entries are multiples of one 200 ms unit
  localparam int SPIN_UNIT_MS     = 200;
  localparam int CLK_MHZ          = 125;
  localparam int SPIN_UNIT_CYCLES = SPIN_UNIT_MS * 1000 * CLK_MHZ;
  localparam int SPIN_PRE_W       = 25;
  localparam int SPIN_UNITS_W     = 6;

  // PWM frame: 15 slots, each PWM_SLOT_CYCLES long
  localparam int          PWM_SLOT_CYCLES = 256;
  localparam logic [3:0]  PWM_LAST_SLOT   = 4'hE;
  localparam logic [7:0]  PWM_SLOT_LAST   = 8'hFF;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } afsl_reg_req_type;

  typedef struct packed {
    logic             valid;
    logic signed [7:0] local_temp;
    logic signed [7:0] remote_temp;
  } afsl_temps_type;

  typedef struct packed {
    logic       running;
    logic [3:0] duty;
  } afsl_loop_state_type;

endpackage

// ==== afsl_loop.sv ====
// One temperature control loop: on/off with hysteresis and linear duty.
// Assumes temp is whole degrees C, two's complement, updated on sample.
`timescale 1ns/100ps
`default_nettype none
module afsl_loop (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              sample,
  input  wire logic signed [7:0] temp,
  input  wire logic [7:0]        param,
  input  wire logic [3:0]        min_code,
  output logic                   running,
  output logic [3:0]             duty
);

  afsl_pkg::afsl_loop_state_type state_reg;
  afsl_pkg::afsl_loop_state_type state_next;

  logic signed [9:0] delta;
  logic [6:0]        fan_on_temp;
  logic [2:0]        span_code;
  logic [10:0]       steps;
  logic [10:0]       sum;
  logic [3:0]        calc;

  always_comb
  begin
    // Field times four gives degrees
    fan_on_temp = {param[afsl_pkg::FAN_ON_TEMP_HI:afsl_pkg::FAN_ON_TEMP_LO], 2'b00};
    span_code   = param[afsl_pkg::SPAN_CODE_HI:0];
    if (span_code > afsl_pkg::SPAN_CODE_MAX)
    begin
      span_code = afsl_pkg::SPAN_CODE_MAX;
    end
    delta = {{2{temp[7]}}, temp} - $signed({3'b000, fan_on_temp});
    // Duty steps of span/10 degrees; curve only shifts with fan-on temp
    if (delta[9])
    begin
      steps = 11'h000;
    end
    else
    begin
      steps = {delta, 1'b0} >> span_code;
    end
    sum = {7'h00, min_code} + steps;
    // Clamp at full duty; full speed point is fan-on temp plus (15 - min_code) steps of span/10
    calc = (sum > 11'(afsl_pkg::DUTY_FULL)) ? afsl_pkg::DUTY_FULL : sum[3:0];
    state_next = state_reg;
    if (sample)
    begin
      if (state_reg.running)
      begin
        state_next.running = (delta > -10'(afsl_pkg::HYSTERESIS_DEG));
      end
      else
      begin
        state_next.running = !delta[9] && (delta != 10'h000);
      end
      state_next.duty = state_next.running ? calc : afsl_pkg::DUTY_OFF;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign running = state_reg.running;
  assign duty    = state_reg.duty;

endmodule
`default_nettype wire

// ==== afsl_top.sv ====
// Automatic fan speed loop: registers, two channel loops, spin-up, PWM.
// Assumes register strobes and temperature samples are synchronous to clk_sys.
// Operation
// - Fan stays off until above fan-on temperature
// - Spin-up phase runs whenever fan switches on
// - Duty rises to full at full-speed temperature
// - Full-speed temperature derived, never a register
// - Fan stops five degrees below fan-on temperature
// - Fan-on temperature settable in four-degree steps
// - Fan-on temperature shifts curve, span sets slope
// - Minimum running duty defaults to one third
// - Spin-up time from fan characteristics bits 2:0
// - Configuration bit 7 selects automatic control
// - Automatic mode active straight after reset
// - Select 00 lets remote loop alone drive
// - Select 11 drives the larger loop duty
// - Local and remote loops programmed independently
// - Fan-on temperature in parameter bits 7:3
// - Control span codes in parameter bits 2:0
// - Minimum duty code from register 0x22 bits
// - Duty rises linearly by span over ten
`timescale 1ns/100ps
`default_nettype none
module afsl_top #(
  parameter int unsigned SPIN_UNIT_CYCLES = afsl_pkg::SPIN_UNIT_CYCLES
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire afsl_pkg::afsl_reg_req_type reg_req,
  output logic [7:0]                     reg_rdata,
  input  wire afsl_pkg::afsl_temps_type   temps,
  output logic                           fan_pwm,
  output logic [3:0]                     duty_code,
  output logic                           fan_running
);

  typedef struct packed {
    logic [7:0]                        main_configuration;
    logic [7:0]                        fan_characteristics;
    logic [7:0]                        min_speed;
    logic [7:0]                        local_param;
    logic [7:0]                        remote_param;
    logic [7:0]                        rdata;
    logic                              fan_on_prev;
    logic                              spinning;
    logic [afsl_pkg::SPIN_PRE_W-1:0]   spin_pre;
    logic [afsl_pkg::SPIN_UNITS_W-1:0] spin_units;
    logic [3:0]                        duty;
    logic [3:0]                        slot;
    logic [7:0]                        slot_pre;
    logic                              pwm;
  } afsl_top_state_type;

  afsl_top_state_type state_reg;
  afsl_top_state_type state_next;

  logic [1:0] loop_running;
  logic [3:0] loop_duty [2];
  logic [7:0] loop_param [2];
  logic       auto_mode;
  logic       fastest;
  logic       fan_on;
  logic [3:0] active_duty;
  logic [3:0] min_code;

  // Spin-up length in 200 ms units
  function automatic logic [afsl_pkg::SPIN_UNITS_W-1:0] spin_units_of(input logic [2:0] code);
    case (code)
      3'h0:    spin_units_of = 6'h01;
      3'h1:    spin_units_of = 6'h02;
      3'h2:    spin_units_of = 6'h03;
      3'h3:    spin_units_of = 6'h04;
      3'h4:    spin_units_of = 6'h05;
      3'h5:    spin_units_of = 6'h0A;
      3'h6:    spin_units_of = 6'h14;
      3'h7:    spin_units_of = 6'h28;
      default: spin_units_of = 6'h0A;
    endcase
  endfunction

  assign loop_param[0] = state_reg.local_param;
  assign loop_param[1] = state_reg.remote_param;
  assign min_code      = state_reg.min_speed[afsl_pkg::MIN_CODE_HI:0];

  // Index 0 local, index 1 remote
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_loop
      afsl_loop u_loop (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .sample   (temps.valid),
        .temp     ((gi == 0) ? temps.local_temp : temps.remote_temp),
        .param    (loop_param[gi]),
        .min_code (min_code),
        .running  (loop_running[gi]),
        .duty     (loop_duty[gi])
      );
    end
  endgenerate

  always_comb
  begin
    auto_mode = state_reg.main_configuration[afsl_pkg::AUTO_MODE_BIT];
    fastest   = state_reg.main_configuration[afsl_pkg::CHAN_SEL_HI:afsl_pkg::CHAN_SEL_LO]
                == afsl_pkg::CHAN_SEL_FASTEST;
    // Unlisted select codes fall back to the remote loop
    if (fastest)
    begin
      fan_on      = loop_running[0] || loop_running[1];
      active_duty = (loop_duty[0] > loop_duty[1]) ? loop_duty[0] : loop_duty[1];
    end
    else
    begin
      fan_on      = loop_running[1];
      active_duty = loop_duty[1];
    end
    fan_on = fan_on && auto_mode;

    state_next = state_reg;

    // Register writes at their documented offsets
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        afsl_pkg::MAIN_CONFIGURATION_OFFSET:  state_next.main_configuration  = reg_req.wdata;
        afsl_pkg::FAN_CHARACTERISTICS_OFFSET: state_next.fan_characteristics = reg_req.wdata;
        afsl_pkg::MIN_SPEED_OFFSET:           state_next.min_speed           = reg_req.wdata;
        afsl_pkg::LOCAL_PARAM_OFFSET:         state_next.local_param         = reg_req.wdata;
        afsl_pkg::REMOTE_PARAM_OFFSET:        state_next.remote_param        = reg_req.wdata;
        default:                              state_next.rdata               = state_reg.rdata;
      endcase
    end

    // Read data registered; unmapped addresses read zero
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        afsl_pkg::MAIN_CONFIGURATION_OFFSET:  state_next.rdata = state_reg.main_configuration;
        afsl_pkg::FAN_CHARACTERISTICS_OFFSET: state_next.rdata = state_reg.fan_characteristics;
        afsl_pkg::MIN_SPEED_OFFSET:           state_next.rdata = state_reg.min_speed;
        afsl_pkg::LOCAL_PARAM_OFFSET:         state_next.rdata = state_reg.local_param;
        afsl_pkg::REMOTE_PARAM_OFFSET:        state_next.rdata = state_reg.remote_param;
        afsl_pkg::LOOP_STATUS_OFFSET:
        begin
          state_next.rdata                            = {4'h0, state_reg.duty};
          state_next.rdata[afsl_pkg::STATUS_SPIN_BIT] = state_reg.spinning;
          state_next.rdata[afsl_pkg::STATUS_ON_BIT]   = state_reg.fan_on_prev;
        end
        default:                              state_next.rdata = 8'h00;
      endcase
    end

    // Spin-up sequencing on each off-to-on transition
    state_next.fan_on_prev = fan_on;
    if (!fan_on)
    begin
      state_next.spinning = 1'b0;
    end
    else if (!state_reg.fan_on_prev)
    begin
      state_next.spinning   = 1'b1;
      state_next.spin_pre   = '0;
      state_next.spin_units = spin_units_of(
                                state_reg.fan_characteristics[afsl_pkg::SPIN_CODE_HI:0]);
    end
    else if (state_reg.spinning)
    begin
      if (state_reg.spin_pre == afsl_pkg::SPIN_PRE_W'(SPIN_UNIT_CYCLES - 1))
      begin
        state_next.spin_pre = '0;
        if (state_reg.spin_units == afsl_pkg::SPIN_UNITS_W'(1))
        begin
          state_next.spinning = 1'b0;
        end
        else
        begin
          state_next.spin_units = state_reg.spin_units - 1'b1;
        end
      end
      else
      begin
        state_next.spin_pre = state_reg.spin_pre + 1'b1;
      end
    end

    // Duty selection; software mode runs at the programmed code
    if (!auto_mode)
    begin
      state_next.duty = min_code;
    end
    else if (!fan_on)
    begin
      state_next.duty = afsl_pkg::DUTY_OFF;
    end
    else if (state_next.spinning)
    begin
      state_next.duty = afsl_pkg::DUTY_FULL;
    end
    else
    begin
      state_next.duty = active_duty;
    end

    // PWM frame of 15 slots so code 15 gives 100 percent
    if (state_reg.slot_pre == afsl_pkg::PWM_SLOT_LAST)
    begin
      state_next.slot_pre = 8'h00;
      state_next.slot     = (state_reg.slot == afsl_pkg::PWM_LAST_SLOT) ? 4'h0
                                                                        : state_reg.slot + 1'b1;
    end
    else
    begin
      state_next.slot_pre = state_reg.slot_pre + 1'b1;
    end
    state_next.pwm = state_reg.slot < state_reg.duty;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg                     <= '0;
      state_reg.main_configuration  <= afsl_pkg::MAIN_CONFIGURATION_RESET;
      state_reg.fan_characteristics <= afsl_pkg::FAN_CHARACTERISTICS_RESET;
      state_reg.min_speed           <= afsl_pkg::MIN_SPEED_RESET;
      state_reg.local_param         <= afsl_pkg::LOCAL_PARAM_RESET;
      state_reg.remote_param        <= afsl_pkg::REMOTE_PARAM_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata   = state_reg.rdata;
  assign fan_pwm     = state_reg.pwm;
  assign duty_code   = state_reg.duty;
  assign fan_running = state_reg.fan_on_prev;

endmodule
`default_nettype wire

// ==== afsl_checker.sv ====
// Checker for the fan speed loop top: spin-up, PWM drive, register reads.
// Assumes it is bound onto afsl_top with SPIN_UNIT_CYCLES handed on.
`timescale 1ns/100ps
`default_nettype none
module afsl_checker #(
  parameter int unsigned SPIN_UNIT_CYCLES = 4
) (
  input wire logic                       clk_sys,
  input wire logic                       rst,
  input wire afsl_pkg::afsl_reg_req_type reg_req,
  input wire logic [7:0]                 reg_rdata,
  input wire afsl_pkg::afsl_temps_type   temps,
  input wire logic                       fan_pwm,
  input wire logic [3:0]                 duty_code,
  input wire logic                       fan_running
);
  logic [7:0]  cfg_reg;
  logic [7:0]  char_reg;
  logic        run_reg;
  logic [31:0] cnt_reg;
  logic [15:0] units;

  always_comb
  begin
    case (char_reg[2:0])
      3'h5: units = 16'h000A;
      3'h6: units = 16'h0014;
      3'h7: units = 16'h0028;
      default: units = 16'(char_reg[2:0]) + 16'h0001;
    endcase
  end

  // Shadows follow writes; cnt_reg counts cycles since fan switch-on
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cfg_reg  <= afsl_pkg::MAIN_CONFIGURATION_RESET;
      char_reg <= afsl_pkg::FAN_CHARACTERISTICS_RESET;
      run_reg  <= 1'b0;
      cnt_reg  <= 32'h00000000;
    end
    else
    begin
      if (reg_req.wr && reg_req.addr == afsl_pkg::MAIN_CONFIGURATION_OFFSET)
        cfg_reg <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == afsl_pkg::FAN_CHARACTERISTICS_OFFSET)
        char_reg <= reg_req.wdata;
      run_reg <= fan_running;
      if (fan_running && !run_reg)
        cnt_reg <= 32'h00000001;
      // Wide enough that full-length spin-up never saturates the count
      else if (cnt_reg != 32'hFFFFFFFF)
        cnt_reg <= cnt_reg + 32'h00000001;
    end
  end

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_off_zero_duty: assert property (
    cfg_reg[7] && $past(cfg_reg[7]) && $past(cfg_reg[7], 2) && !fan_running |-> duty_code == 4'h0)
    else $error("duty not zero while fan off");
  a_spin_start: assert property ($rose(fan_running) |-> duty_code == 4'hF)
    else $error("no full duty at switch-on");
  a_spin_hold: assert property (
    fan_running && run_reg && (32'(cnt_reg) + 1 < 32'(units) * SPIN_UNIT_CYCLES)
    |-> duty_code == 4'hF)
    else $error("spin-up ended early");
  a_pwm_full: assert property ($past(duty_code) == 4'hF |-> fan_pwm)
    else $error("pwm low at full duty");
  a_pwm_off: assert property ($past(duty_code) == 4'h0 |-> !fan_pwm)
    else $error("pwm high at zero duty");
  a_run_cause: assert property (
    $changed(fan_running) && cfg_reg[7] && $past(cfg_reg[7]) |-> $past(temps.valid, 2))
    else $error("fan state changed without a sample");
  a_cfg_read: assert property (
    reg_req.rd && reg_req.addr == afsl_pkg::MAIN_CONFIGURATION_OFFSET
    |=> reg_rdata == $past(cfg_reg))
    else $error("configuration readback wrong");
  a_char_read: assert property (
    reg_req.rd && reg_req.addr == afsl_pkg::FAN_CHARACTERISTICS_OFFSET
    |=> reg_rdata == $past(char_reg))
    else $error("fan characteristics readback wrong");

  c_spin: cover property ($rose(fan_running));
  c_stop: cover property ($fell(fan_running));
  c_mid: cover property (fan_running && duty_code > 4'h0 && duty_code < 4'hF);
endmodule

bind afsl_top afsl_checker #(.SPIN_UNIT_CYCLES(SPIN_UNIT_CYCLES)) u_checker (
  .clk_sys     (clk_sys),
  .rst         (rst),
  .reg_req     (reg_req),
  .reg_rdata   (reg_rdata),
  .temps       (temps),
  .fan_pwm     (fan_pwm),
  .duty_code   (duty_code),
  .fan_running (fan_running)
);
`default_nettype wire

// ==== afsl_fan_model.sv ====
// Fan partner: integrates the PWM drive over one full frame.
// Assumes the fixed frame of 15 slots of PWM_SLOT_CYCLES clocks.
`timescale 1ns/100ps
`default_nettype none
module afsl_fan_model (
  input  wire logic   clk_sys,
  input  wire logic   fan_pwm,
  output logic [11:0] high_cycles
);
  localparam int FRAME = 15 * afsl_pkg::PWM_SLOT_CYCLES;
  int          pos;
  logic [11:0] acc;

  // Any one-frame window sees the same drive, so no phase lock needed
  initial
  begin
    pos = 0;
    acc = 12'h000;
    high_cycles = 12'h000;
  end
  always @(posedge clk_sys)
  begin
    if (pos == FRAME - 1)
    begin
      high_cycles <= acc + 12'(fan_pwm);
      acc <= 12'h000;
      pos <= 0;
    end
    else
    begin
      acc <= acc + 12'(fan_pwm);
      pos <= pos + 1;
    end
  end
endmodule
`default_nettype wire

// ==== test_auto_fan_speed_loop.sv ====
// Self-checking bench for the automatic fan speed loop.
// Assumes afsl_top, the fan model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_auto_fan_speed_loop;
  localparam int SPIN = 4;
  typedef struct {
    logic [1:0] sel;
    logic [7:0] lp;
    logic [7:0] rp;
    logic [3:0] mn;
    logic [7:0] lt;
    logic [7:0] rt;
    logic [3:0] duty;
  } afsl_row_type;
  // Select, local param, remote param, min code, temps, expected duty
  afsl_row_type rows [11] = '{
    '{2'h0, 8'h00, 8'h03, 4'h5, 8'h64, 8'h14, 4'hA},
    '{2'h3, 8'h00, 8'h03, 4'h5, 8'h64, 8'h14, 4'hF},
    '{2'h3, 8'h2B, 8'h04, 4'h5, 8'h28, 8'h28, 4'hA},
    '{2'h3, 8'h2B, 8'h04, 4'h5, 8'h14, 8'h14, 4'h7},
    '{2'h0, 8'h00, 8'h08, 4'h5, 8'h64, 8'h04, 4'h0},
    '{2'h0, 8'h00, 8'h08, 4'h5, 8'h00, 8'h05, 4'h7},
    '{2'h0, 8'h00, 8'h10, 4'h5, 8'h00, 8'h09, 4'h7},
    '{2'h0, 8'h00, 8'h03, 4'h8, 8'h00, 8'h1B, 4'hE},
    '{2'h0, 8'h00, 8'h03, 4'h8, 8'h00, 8'h1C, 4'hF},
    '{2'h0, 8'h00, 8'h04, 4'h5, 8'h00, 8'h50, 4'hF},
    '{2'h1, 8'h00, 8'h03, 4'h5, 8'h64, 8'h14, 4'hA}};
  int units_tab [8] = '{1, 2, 3, 4, 5, 10, 20, 40};
  logic                       clk_sys = 1'b0;
  logic                       rst;
  afsl_pkg::afsl_reg_req_type reg_req;
  logic [7:0]                 reg_rdata;
  afsl_pkg::afsl_temps_type   temps;
  logic                       fan_pwm;
  logic [3:0]                 duty_code;
  logic                       fan_running;
  logic [11:0]                high_cycles;
  int                         fail_count;
  int                         num_checks;
  int                         n;

  afsl_top #(
    .SPIN_UNIT_CYCLES (SPIN)
  ) DUT (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .reg_req     (reg_req),
    .reg_rdata   (reg_rdata),
    .temps       (temps),
    .fan_pwm     (fan_pwm),
    .duty_code   (duty_code),
    .fan_running (fan_running)
  );
  afsl_fan_model u_fan (
    .clk_sys     (clk_sys),
    .fan_pwm     (fan_pwm),
    .high_cycles (high_cycles)
  );

  always #4 clk_sys = ~clk_sys;

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    reg_req.wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    reg_req.rd = 1'b0;
    chk({4'h0, reg_rdata}, {4'h0, e});
  endtask
  // Valid is a one-cycle pulse; both temperatures travel together
  task automatic smp(input logic [7:0] l, input logic [7:0] r);
    @(negedge clk_sys);
    temps = '{1'b1, l, r};
    @(negedge clk_sys);
    temps.valid = 1'b0;
  endtask
  task automatic resets;
    rd_chk(8'h00, 8'h80);
    rd_chk(8'h20, 8'h1D);
    rd_chk(8'h22, 8'h05);
    rd_chk(8'h24, 8'h40);
    rd_chk(8'h25, 8'h60);
    rd_chk(8'h10, 8'h00);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #400000;
    fail_count++;
    summarize();
  end

  initial
  begin
    fail_count = 0;
    num_checks = 0;
    rst = 1'b1;
    reg_req = '0;
    temps = '0;
    idle(4);
    rst = 1'b0;
    resets();
    foreach (rows[i])
    begin
      smp(8'h9C, 8'h9C);
      wr(afsl_pkg::MIN_SPEED_OFFSET, {4'h0, rows[i].mn});
      wr(afsl_pkg::LOCAL_PARAM_OFFSET, rows[i].lp);
      wr(afsl_pkg::REMOTE_PARAM_OFFSET, rows[i].rp);
      wr(afsl_pkg::MAIN_CONFIGURATION_OFFSET, {1'b1, rows[i].sel, 5'h00});
      smp(rows[i].lt, rows[i].rt);
      idle(60);
      chk({8'h00, duty_code}, {8'h00, rows[i].duty});
      chk({11'h000, fan_running}, {11'h000, rows[i].duty != 4'h0});
    end
    // Every spin-up code, counting full-duty cycles after switch-on
    wr(afsl_pkg::REMOTE_PARAM_OFFSET, 8'h08);
    wr(afsl_pkg::MIN_SPEED_OFFSET, 8'h05);
    wr(afsl_pkg::MAIN_CONFIGURATION_OFFSET, 8'h80);
    for (int c = 0; c < 8; c++)
    begin
      smp(8'h9C, 8'h9C);
      wr(afsl_pkg::FAN_CHARACTERISTICS_OFFSET, {5'h03, c[2:0]});
      rd_chk(afsl_pkg::FAN_CHARACTERISTICS_OFFSET, {5'h03, c[2:0]});
      smp(8'h00, 8'h05);
      n = 0;
      for (int k = 0; k < 400 && duty_code !== 4'h7; k++)
      begin
        @(negedge clk_sys);
        if (duty_code === 4'hF)
          n++;
      end
      chk(12'(n), 12'(units_tab[c] * SPIN));
    end
    // Hysteresis band keeps minimum duty; five below stops the fan
    smp(8'h00, 8'h00);
    idle(4);
    chk({8'h00, duty_code}, 12'h005);
    // Status is read-only: the write must leave it untouched
    wr(afsl_pkg::LOOP_STATUS_OFFSET, 8'hFF);
    rd_chk(afsl_pkg::LOOP_STATUS_OFFSET, 8'h25);
    idle(7700);
    chk(high_cycles, 12'h500);
    smp(8'h00, 8'hFF);
    idle(4);
    chk({11'h000, fan_running}, 12'h000);
    idle(7700);
    chk(high_cycles, 12'h000);
    wr(afsl_pkg::MAIN_CONFIGURATION_OFFSET, 8'h00);
    idle(4);
    chk({8'h00, duty_code}, 12'h005);
    wr(afsl_pkg::MAIN_CONFIGURATION_OFFSET, 8'h80);
    // Reset while the fan runs
    smp(8'h00, 8'h64);
    idle(10);
    rst = 1'b1;
    idle(4);
    chk({7'h00, fan_running, duty_code}, 12'h000);
    rst = 1'b0;
    resets();
    summarize();
  end
endmodule
`default_nettype wire
